/* File: tb/core_trim_bank_checker.sv */
/* Port checker for the trim bank.
   Assumes a bind onto core_trim_bank, one clock domain. */
`timescale 1ns/100ps
module core_trim_bank_checker (
    input wire logic                          i_clock,
    input wire logic                          i_rst,
    input wire logic [trim_pkg::ADDR_W-1:0]   i_addr,
    input wire logic [trim_pkg::DATA_W-1:0]   i_wdata,
    input wire logic                          i_write,
    input wire logic                          i_read,
    input wire logic                          i_fuse_valid,
    input wire logic                          i_fuse_reload,
    input wire logic [trim_pkg::OFFSET_W-1:0] i_fuse_core4_offset,
    input wire logic                          i_core2_second_input,
    input wire logic [trim_pkg::DATA_W-1:0]   o_rdata,
    input wire logic                          o_trim_ready,
    input wire logic [trim_pkg::OFFSET_W-1:0] o_core4_offset,
    input wire logic [trim_pkg::GAIN_W-1:0]   o_core2_gain,
    input wire logic [trim_pkg::GAIN_W-1:0]   o_core4_gain
);
    import trim_pkg::*;
    // ==========================================
    // Accepted write
    // ==========================================
    wire wr_ok = i_write && o_trim_ready && !(i_fuse_reload && i_fuse_valid);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    AST_RD_IDLE: assert property (!$past(i_read) |-> o_rdata == 16'h0000)
        else $error("read data not idle");
    AST_WR_OFS: assert property (wr_ok && i_addr == CORE4_OFFSET_TRIM_ADDR
        |=> o_core4_offset == $past(i_wdata[11:0])) else $error("offset not applied");
    AST_WR_G4: assert property (wr_ok && i_addr == CORE4_FINE_GAIN_ADDR
        |=> o_core4_gain == $past(i_wdata[4:0])) else $error("gain not applied");
    AST_G2A: assert property (wr_ok && i_addr == CORE2_FIRST_INPUT_FINE_GAIN_ADDR
        && !i_core2_second_input |=> o_core2_gain == $past(i_wdata[4:0]))
        else $error("first input gain not used");
    AST_G2B: assert property (wr_ok && i_addr == CORE2_SECOND_INPUT_FINE_GAIN_ADDR
        && i_core2_second_input |=> o_core2_gain == $past(i_wdata[4:0]))
        else $error("second input gain not used");
    AST_RD_OFS: assert property (i_read && i_addr == CORE4_OFFSET_TRIM_ADDR
        |=> o_rdata[11:0] == $past(o_core4_offset)) else $error("offset read wrong");
    AST_RD_G4: assert property (i_read && i_addr == CORE4_FINE_GAIN_ADDR |=>
        o_rdata[15:8] == 8'h00 && o_rdata[4:0] == $past(o_core4_gain))
        else $error("gain read wrong");
    AST_HOLE: assert property (i_read && i_addr == 12'h033D |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_LOAD: assert property (!o_trim_ready && i_fuse_valid |=> o_trim_ready
        && o_core4_offset == $past(i_fuse_core4_offset)) else $error("fuse load wrong");
endmodule

/* File: tb/core_trim_bank_tb_top.sv */
/* Testbench for the trim bank: fuse load, writes, read-back,
   input selection, unmapped places and reload.
   Assumes trim_pkg, the design and the checker compiled first. */
`timescale 1ns/100ps
module core_trim_bank_tb_top;
    import trim_pkg::*;
    logic i_clock, i_rst, i_write, i_read, i_fuse_valid, i_fuse_reload, o_trim_ready;
    logic i_core2_second_input, i_core3_fourth_input;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata;
    logic [OFFSET_W-1:0] i_fuse_core4_offset, i_fuse_core5_offset, o_core4_offset, o_core5_offset;
    logic [GAIN_W-1:0] i_fuse_core0_gain, i_fuse_core1_gain, i_fuse_core2_first_gain;
    logic [GAIN_W-1:0] i_fuse_core2_second_gain, i_fuse_core3_third_gain, i_fuse_core3_fourth_gain;
    logic [GAIN_W-1:0] i_fuse_core4_gain, i_fuse_core5_gain, o_core0_gain, o_core1_gain;
    logic [GAIN_W-1:0] o_core2_gain, o_core3_gain, o_core4_gain, o_core5_gain;
    int bad_count = 0;
    int compares = 0;
    int n;
    logic [ADDR_W-1:0] adr [10] = '{CORE4_OFFSET_TRIM_ADDR, CORE5_OFFSET_TRIM_ADDR, 12'h0360,
        12'h0361, 12'h0362, 12'h0363, 12'h0364, 12'h0365, 12'h0366, 12'h0367};
    logic [DATA_W-1:0] val [10] = '{16'h0ABC, 16'h0543, 16'h0015, 16'h000A, 16'h001F,
        16'h0011, 16'h0003, 16'h001C, 16'h0019, 16'h0006};

    core_trim_bank DUT (
        .i_clock, .i_rst, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
        .i_fuse_valid, .i_fuse_reload, .i_fuse_core4_offset, .i_fuse_core5_offset,
        .i_fuse_core0_gain, .i_fuse_core1_gain, .i_fuse_core2_first_gain,
        .i_fuse_core2_second_gain, .i_fuse_core3_third_gain, .i_fuse_core3_fourth_gain,
        .i_fuse_core4_gain, .i_fuse_core5_gain, .i_core2_second_input, .i_core3_fourth_input,
        .o_trim_ready, .o_core4_offset, .o_core5_offset, .o_core0_gain, .o_core1_gain,
        .o_core2_gain, .o_core3_gain, .o_core4_gain, .o_core5_gain
    );
    // ==========================================
    // Tasks
    // ==========================================
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (bad_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        @(negedge i_clock);
        chk(64'(o_rdata), 64'(e));
        @(posedge i_clock);
    endtask
    task automatic outs(input logic [53:0] e);
        @(negedge i_clock);
        chk(64'({o_core4_offset, o_core5_offset, o_core0_gain, o_core1_gain, o_core2_gain,
            o_core3_gain, o_core4_gain, o_core5_gain}), 64'(e));
        @(posedge i_clock);
    endtask
    // ==========================================
    // Clock, watchdog, sequence
    // ==========================================
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    initial begin
        repeat (3000) @(posedge i_clock);
        bad_count++;
        stop_test();
    end
    initial begin
        {i_rst, i_write, i_read, i_fuse_valid, i_fuse_reload} = 5'b10000;
        {i_core2_second_input, i_core3_fourth_input, i_addr, i_wdata} = '0;
        {i_fuse_core4_offset, i_fuse_core5_offset} = {12'h123, 12'h456};
        {i_fuse_core0_gain, i_fuse_core1_gain, i_fuse_core2_first_gain} = {5'h01, 5'h02, 5'h03};
        {i_fuse_core2_second_gain, i_fuse_core3_third_gain} = {5'h04, 5'h05};
        {i_fuse_core3_fourth_gain, i_fuse_core4_gain, i_fuse_core5_gain} = {5'h06, 5'h07, 5'h08};
        repeat (10) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        wr(CORE4_FINE_GAIN_ADDR, 16'h0015);
        rd(CORE4_OFFSET_TRIM_ADDR, 16'h0000);
        i_fuse_valid <= 1'b1;
        for (n = 0; n < 8 && o_trim_ready !== 1'b1; n++) begin
            @(negedge i_clock);
        end
        if (o_trim_ready !== 1'b1) begin
            bad_count++;
            stop_test();
        end
        @(posedge i_clock);
        outs({12'h123, 12'h456, 5'h01, 5'h02, 5'h03, 5'h05, 5'h07, 5'h08});
        rd(CORE5_OFFSET_TRIM_ADDR, 16'h0456);
        rd(CORE3_FOURTH_INPUT_FINE_GAIN_ADDR, 16'h0006);
        for (n = 0; n < 10; n++) begin
            wr(adr[n], val[n]);
            rd(adr[n], val[n]);
        end
        outs({12'hABC, 12'h543, 5'h15, 5'h0A, 5'h1F, 5'h03, 5'h19, 5'h06});
        i_core2_second_input <= 1'b1;
        i_core3_fourth_input <= 1'b1;
        @(posedge i_clock);
        outs({12'hABC, 12'h543, 5'h15, 5'h0A, 5'h11, 5'h1C, 5'h19, 5'h06});
        wr(CORE2_SECOND_INPUT_FINE_GAIN_ADDR, 16'h0009);
        outs({12'hABC, 12'h543, 5'h15, 5'h0A, 5'h09, 5'h1C, 5'h19, 5'h06});
        wr(12'h033F, 16'h0FFF);
        rd(12'h033D, 16'h0000);
        rd(CORE5_OFFSET_TRIM_ADDR, 16'h0543);
        i_fuse_core4_gain <= 5'h1E;
        i_fuse_core5_offset <= 12'hFFF;
        i_fuse_reload <= 1'b1;
        wr(CORE4_FINE_GAIN_ADDR, 16'h0004);
        i_fuse_reload <= 1'b0;
        outs({12'h123, 12'hFFF, 5'h01, 5'h02, 5'h04, 5'h06, 5'h1E, 5'h08});
        stop_test();
    end
endmodule

bind core_trim_bank core_trim_bank_checker u_checker (
    .i_clock, .i_rst, .i_addr, .i_wdata, .i_write, .i_read, .i_fuse_valid, .i_fuse_reload,
    .i_fuse_core4_offset, .i_core2_second_input, .o_rdata, .o_trim_ready, .o_core4_offset,
    .o_core2_gain, .o_core4_gain
);

/* File: verilog/core_trim_bank.sv */
/*
 * Trim register bank: offset trims for converter cores 4 and 5
 * and fine gain trims for cores 0 to 5, with per-input gain
 * selection on cores 2 and 3 and factory defaults from fuses.
 * Assumes fuse values, input selects and the register port all
 * come from logic on i_clock.
 */
`timescale 1ns/100ps

module core_trim_bank (
    input  wire logic                          i_clock,
    input  wire logic                          i_rst,
    // Register port
    input  wire logic [trim_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [trim_pkg::DATA_W-1:0]   i_wdata,
    input  wire logic                          i_write,
    input  wire logic                          i_read,
    output logic      [trim_pkg::DATA_W-1:0]   o_rdata,
    // Factory fuse storage
    input  wire logic                          i_fuse_valid,
    input  wire logic                          i_fuse_reload,
    input  wire logic [trim_pkg::OFFSET_W-1:0] i_fuse_core4_offset,
    input  wire logic [trim_pkg::OFFSET_W-1:0] i_fuse_core5_offset,
    input  wire logic [trim_pkg::GAIN_W-1:0]   i_fuse_core0_gain,
    input  wire logic [trim_pkg::GAIN_W-1:0]   i_fuse_core1_gain,
    input  wire logic [trim_pkg::GAIN_W-1:0]   i_fuse_core2_first_gain,
    input  wire logic [trim_pkg::GAIN_W-1:0]   i_fuse_core2_second_gain,
    input  wire logic [trim_pkg::GAIN_W-1:0]   i_fuse_core3_third_gain,
    input  wire logic [trim_pkg::GAIN_W-1:0]   i_fuse_core3_fourth_gain,
    input  wire logic [trim_pkg::GAIN_W-1:0]   i_fuse_core4_gain,
    input  wire logic [trim_pkg::GAIN_W-1:0]   i_fuse_core5_gain,
    // Active analog input of the interleaved cores
    input  wire logic                          i_core2_second_input,
    input  wire logic                          i_core3_fourth_input,
    // Datapath trims
    output logic                               o_trim_ready,
    output logic      [trim_pkg::OFFSET_W-1:0] o_core4_offset,
    output logic      [trim_pkg::OFFSET_W-1:0] o_core5_offset,
    output logic      [trim_pkg::GAIN_W-1:0]   o_core0_gain,
    output logic      [trim_pkg::GAIN_W-1:0]   o_core1_gain,
    output logic      [trim_pkg::GAIN_W-1:0]   o_core2_gain,
    output logic      [trim_pkg::GAIN_W-1:0]   o_core3_gain,
    output logic      [trim_pkg::GAIN_W-1:0]   o_core4_gain,
    output logic      [trim_pkg::GAIN_W-1:0]   o_core5_gain
);
    import trim_pkg::*;

    // =========================================================
    // State
    // =========================================================
    bank_t state_reg;
    bank_t state_next;

    logic [NUM_GAIN_REG-1:0][GAIN_W-1:0]   fuse_gain;
    logic [NUM_OFFSET-1:0][OFFSET_W-1:0]   fuse_offset;
    logic [NUM_OFFSET-1:0][ADDR_W-1:0]     offset_addr;

    assign fuse_offset = {i_fuse_core5_offset, i_fuse_core4_offset};
    assign offset_addr = {CORE5_OFFSET_TRIM_ADDR, CORE4_OFFSET_TRIM_ADDR};
    assign fuse_gain   = {i_fuse_core5_gain,
                          i_fuse_core4_gain,
                          i_fuse_core3_fourth_gain,
                          i_fuse_core3_third_gain,
                          i_fuse_core2_second_gain,
                          i_fuse_core2_first_gain,
                          i_fuse_core1_gain,
                          i_fuse_core0_gain};

    // =========================================================
    // Address helpers
    // =========================================================
    // Byte address of gain register idx
    function automatic logic [ADDR_W-1:0] gain_addr(input int idx);
        gain_addr = CORE0_FINE_GAIN_ADDR + ADDR_W'(idx);
    endfunction

    // Read-back value; unmapped addresses read zero
    function automatic logic [DATA_W-1:0] read_value(
        input bank_t                s,
        input logic [ADDR_W-1:0]    a
    );
        logic [DATA_W-1:0] v;
        v = READ_IDLE_VALUE;
        for (int i = 0; i < NUM_OFFSET; i++) begin
            if (a == offset_addr[i]) begin
                v = s.offset[i];
            end
        end
        for (int i = 0; i < NUM_GAIN_REG; i++) begin
            if (a == gain_addr(i)) begin
                v = {{(DATA_W-GAIN_REG_W){1'b0}}, s.gain[i]};
            end
        end
        return v;
    endfunction

    // =========================================================
    // Next state
    // =========================================================
    always_comb begin
        state_next       = state_reg;
        state_next.rdata = READ_IDLE_VALUE;

        case (state_reg.state)
            ST_WAIT_FUSE: begin
                // Hold reset values until fuse contents are valid
                if (i_fuse_valid) begin
                    for (int i = 0; i < NUM_OFFSET; i++) begin
                        state_next.offset[i] = {{(OFFSET_REG_W-OFFSET_W){1'b0}},
                                                fuse_offset[i]};
                    end
                    for (int i = 0; i < NUM_GAIN_REG; i++) begin
                        state_next.gain[i] = {{(GAIN_REG_W-GAIN_W){1'b0}},
                                              fuse_gain[i]};
                    end
                    state_next.ready = 1'b1;
                    state_next.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (i_fuse_reload && i_fuse_valid) begin
                    // Restore factory defaults; wins over a write
                    for (int i = 0; i < NUM_OFFSET; i++) begin
                        state_next.offset[i] = {{(OFFSET_REG_W-OFFSET_W){1'b0}},
                                                fuse_offset[i]};
                    end
                    for (int i = 0; i < NUM_GAIN_REG; i++) begin
                        state_next.gain[i] = {{(GAIN_REG_W-GAIN_W){1'b0}},
                                              fuse_gain[i]};
                    end
                end else if (i_write) begin
                    // Full width stored so reserved bits read back
                    for (int i = 0; i < NUM_OFFSET; i++) begin
                        if (i_addr == offset_addr[i]) begin
                            state_next.offset[i] = i_wdata;
                        end
                    end
                    for (int i = 0; i < NUM_GAIN_REG; i++) begin
                        if (i_addr == gain_addr(i)) begin
                            state_next.gain[i] = i_wdata[GAIN_REG_W-1:0];
                        end
                    end
                end
            end
            default: begin
                state_next.state = ST_WAIT_FUSE;
                state_next.ready = 1'b0;
            end
        endcase

        // Read data of the current contents, shown next cycle only
        if (i_read) begin
            state_next.rdata = read_value(state_reg, i_addr);
        end

        // Per-input gain of the interleaved cores
        state_next.core2_gain = i_core2_second_input
            ? state_next.gain[GAIN_IDX_CORE2_SECOND][GAIN_LSB +: GAIN_W]
            : state_next.gain[GAIN_IDX_CORE2_FIRST][GAIN_LSB +: GAIN_W];
        state_next.core3_gain = i_core3_fourth_input
            ? state_next.gain[GAIN_IDX_CORE3_FOURTH][GAIN_LSB +: GAIN_W]
            : state_next.gain[GAIN_IDX_CORE3_THIRD][GAIN_LSB +: GAIN_W];
    end

    // =========================================================
    // Registers
    // =========================================================
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg.state      <= ST_WAIT_FUSE;
            state_reg.offset     <= {NUM_OFFSET{OFFSET_TRIM_RESET}};
            state_reg.gain       <= {NUM_GAIN_REG{GAIN_TRIM_RESET}};
            state_reg.core2_gain <= GAIN_TRIM_RESET[GAIN_LSB +: GAIN_W];
            state_reg.core3_gain <= GAIN_TRIM_RESET[GAIN_LSB +: GAIN_W];
            state_reg.rdata      <= READ_IDLE_VALUE;
            state_reg.ready      <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // =========================================================
    // Outputs, straight from the state flops
    // =========================================================
    assign o_rdata        = state_reg.rdata;
    assign o_trim_ready   = state_reg.ready;
    // Unsigned offset fields, reserved bits not applied
    assign o_core4_offset = state_reg.offset[0][OFFSET_LSB +: OFFSET_W];
    assign o_core5_offset = state_reg.offset[1][OFFSET_LSB +: OFFSET_W];
    assign o_core0_gain   = state_reg.gain[GAIN_IDX_CORE0][GAIN_LSB +: GAIN_W];
    assign o_core1_gain   = state_reg.gain[GAIN_IDX_CORE1][GAIN_LSB +: GAIN_W];
    assign o_core2_gain   = state_reg.core2_gain;
    assign o_core3_gain   = state_reg.core3_gain;
    assign o_core4_gain   = state_reg.gain[GAIN_IDX_CORE4][GAIN_LSB +: GAIN_W];
    assign o_core5_gain   = state_reg.gain[GAIN_IDX_CORE5][GAIN_LSB +: GAIN_W];

endmodule

/* File: verilog/trim_pkg.sv */
/*
 * Constants, state encoding and state record for the converter
 * core offset and fine gain trim bank.
 * Assumes a byte-addressed register port with 16-bit write data.
 */
package trim_pkg;

    // =========================================================
    // Register port geometry
    // =========================================================
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;

    // =========================================================
    // Register offsets
    // =========================================================
    localparam logic [ADDR_W-1:0] CORE4_OFFSET_TRIM_ADDR           = 12'h033C;
    localparam logic [ADDR_W-1:0] CORE5_OFFSET_TRIM_ADDR           = 12'h033E;
    localparam logic [ADDR_W-1:0] CORE0_FINE_GAIN_ADDR             = 12'h0360;
    localparam logic [ADDR_W-1:0] CORE1_FINE_GAIN_ADDR             = 12'h0361;
    localparam logic [ADDR_W-1:0] CORE2_FIRST_INPUT_FINE_GAIN_ADDR = 12'h0362;
    localparam logic [ADDR_W-1:0] CORE2_SECOND_INPUT_FINE_GAIN_ADDR = 12'h0363;
    localparam logic [ADDR_W-1:0] CORE3_THIRD_INPUT_FINE_GAIN_ADDR = 12'h0364;
    localparam logic [ADDR_W-1:0] CORE3_FOURTH_INPUT_FINE_GAIN_ADDR = 12'h0365;
    localparam logic [ADDR_W-1:0] CORE4_FINE_GAIN_ADDR             = 12'h0366;
    localparam logic [ADDR_W-1:0] CORE5_FINE_GAIN_ADDR             = 12'h0367;

    // =========================================================
    // Field layout
    // =========================================================
    localparam int OFFSET_REG_W  = 16;
    localparam int OFFSET_W      = 12;
    localparam int OFFSET_LSB    = 0;
    localparam int GAIN_REG_W    = 8;
    localparam int GAIN_W        = 5;
    localparam int GAIN_LSB      = 0;
    localparam int NUM_OFFSET    = 2;
    localparam int NUM_GAIN_REG  = 8;

    // Gain register indices, counted from the core 0 register
    localparam int GAIN_IDX_CORE0        = 0;
    localparam int GAIN_IDX_CORE1        = 1;
    localparam int GAIN_IDX_CORE2_FIRST  = 2;
    localparam int GAIN_IDX_CORE2_SECOND = 3;
    localparam int GAIN_IDX_CORE3_THIRD  = 4;
    localparam int GAIN_IDX_CORE3_FOURTH = 5;
    localparam int GAIN_IDX_CORE4        = 6;
    localparam int GAIN_IDX_CORE5        = 7;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [OFFSET_REG_W-1:0] OFFSET_TRIM_RESET = 16'h0000;
    localparam logic [GAIN_REG_W-1:0]   GAIN_TRIM_RESET   = 8'h00;
    localparam logic [DATA_W-1:0]       READ_IDLE_VALUE   = 16'h0000;

    // =========================================================
    // Control state and state record
    // =========================================================
    typedef enum logic [1:0] {
        ST_WAIT_FUSE = 2'b01,
        ST_RUN       = 2'b10
    } state_t;

    typedef struct packed {
        state_t                                      state;
        logic [NUM_OFFSET-1:0][OFFSET_REG_W-1:0]     offset;
        logic [NUM_GAIN_REG-1:0][GAIN_REG_W-1:0]     gain;
        logic [GAIN_W-1:0]                           core2_gain;
        logic [GAIN_W-1:0]                           core3_gain;
        logic [DATA_W-1:0]                           rdata;
        logic                                        ready;
    } bank_t;

endpackage
